// ---- lia_irq_map.vh ----
// Register offsets, field positions, reset values and timing counts of the latched interrupt aggregator
`ifndef LIA_IRQ_MAP_VH
`define LIA_IRQ_MAP_VH

`define LIA_ADDR_W 18
`define LIA_OFS_OUT_CTRL 18'h02710
`define LIA_OFS_SUMMARY 18'h18004
`define LIA_OFS_CLOCK_FLAGS 18'h18010
`define LIA_OFS_BOOT_FLAGS 18'h18014
`define LIA_OFS_SIGDET_FLAGS 18'h18020
`define LIA_OFS_LOOP_FLAGS 18'h18024
`define LIA_OFS_PIN_FLAGS 18'h18038

`define LIA_BIT_GLOBAL_MASK 11
`define LIA_BIT_POLARITY 10
`define LIA_BIT_DRIVE 9
`define LIA_BIT_SUMMARY 0
`define LIA_BIT_CLK_ERR 10
`define LIA_BIT_CLK_FAIL 8
`define LIA_BIT_BOOT 3
`define LIA_BIT_SIGDET_LO 16
`define LIA_BIT_REF_LOST 8
`define LIA_BIT_LOCK_LOST 1
`define LIA_BIT_LOCK_GAINED 0
`define LIA_BIT_PIN_LO 16

`define LIA_RST_GLOBAL_MASK 1'h0
`define LIA_RST_POLARITY 1'h1
`define LIA_RST_DRIVE 1'h1
`define LIA_RST_SOURCE_MASK 32'hffff_fffb

`define LIA_CLK_HZ 40000000
`define LIA_SLOW_CLK_HZ 32768
`define LIA_SLOW_DIV (`LIA_CLK_HZ / `LIA_SLOW_CLK_HZ)
`define LIA_DEBOUNCE_TICKS 4

`endif

// ---- lia_pin_debounce.v ----
// Per-pin debounce filter advanced by the slow tick
`timescale 1ns/10ps
module lia_pin_debounce #(
    parameter WIDTH = 8,
    parameter TICKS = 4,
    parameter CW = 4
) (
    input wire clock,
    input wire nrst,
    input wire tick,
    input wire [WIDTH-1:0] enable,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    // Counter step kept at counter width so no operand is silently widened
    localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};
    reg [CW-1:0] cnt_reg [0:WIDTH-1];
    integer i;

    always @(posedge clock) begin
        if (!nrst) begin
            dout <= {WIDTH{1'b0}};
            for (i = 0; i < WIDTH; i = i + 1) begin
                cnt_reg[i] <= {CW{1'b0}};
            end
        end else begin
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (!enable[i]) begin
                    dout[i] <= din[i];
                    cnt_reg[i] <= {CW{1'b0}};
                end else if (din[i] == dout[i]) begin
                    // Any return to the old level restarts the wait
                    cnt_reg[i] <= {CW{1'b0}};
                end else if (tick) begin
                    if (cnt_reg[i] == TICKS[CW-1:0] - CNT_ONE) begin
                        dout[i] <= din[i];
                        cnt_reg[i] <= {CW{1'b0}};
                    end else begin
                        cnt_reg[i] <= cnt_reg[i] + CNT_ONE;
                    end
                end
            end
        end
    end
endmodule // lia_pin_debounce

// ---- lia_irq_aggregator.v ----
// Latching interrupt aggregator with masked request pin output
// Overview of operation
// [R1] One flag per input, set on a detected edge, not on level; detector, lock and pin inputs have two flags, level-mode pins set on level.
// [R2] Some sources flag rising edges only; others have separate rise and fall flags.
// [R3] Any combination of inputs can raise a request.
// [R4] Flags readable at any time, whether or not the request is asserted.
// [R5] Live unlatched value of every source is readable.
// [R6] Per-source mask; masked flags still latch but never drive the request.
// [R7] Request is the OR of all set unmasked flags.
// [R8] Flag stays set until host writes one to its bit; zero leaves it.
// [R9] Request stays asserted until every unmasked flag is cleared.
// [R10] Pin trigger fields choose edge or level triggering for pin sources.
// [R11] Per-pin debounce on slow clock; host keeps slow clock running.
// [R12] Global mask bit 11 of output control suppresses request; resets to zero.
// [R13] Summary bit 0 at 0x18004 shows unmasked OR, ignoring global mask.
// [R14] Polarity bit 10, reset one: one active low, zero active high.
// [R15] Drive bit 9, reset one: one open drain, zero push-pull.
// [R16] Request routed to a general pin ignores the polarity bit.
// [R17] After reset only boot-complete is unmasked; pin falls when boot done.
// [R18] 0x18010 holds clock error bit 10, fail bit 8; 0x18014 boot bit 3.
// [R19] 0x18020 holds detector fall/rise pairs, fall odd, rise even, bits 25..16.
// [R20] 0x18024 holds reference lost bit 8, lock lost bit 1, lock gained bit 0.
// [R21] Inputs pass two synchronising flops; edges compare with previous cycle.
// [R22] A new event in the cycle of its clear keeps the flag set.
`timescale 1ns/10ps
`include "lia_irq_map.vh"
module lia_irq_aggregator #(
    parameter SLOW_DIV = `LIA_SLOW_DIV,
    parameter DEBOUNCE_TICKS = `LIA_DEBOUNCE_TICKS
) (
    input wire clock,
    input wire nrst,
    input wire [`LIA_ADDR_W-1:0] reg_addr,
    input wire reg_write,
    input wire reg_read,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    output reg reg_rvalid,
    input wire sysclk_err_in,
    input wire sysclk_fail_in,
    input wire boot_done_in,
    input wire [4:0] sig_detect_in,
    input wire loop_ref_lost_in,
    input wire loop_lock_in,
    input wire [7:0] pin_in,
    input wire [7:0] pin_rise_trigger_cfg,
    input wire [7:0] pin_fall_trigger_cfg,
    input wire [7:0] pin_debounce_en,
    input wire slow_clock_enable,
    input wire mask_load,
    input wire [31:0] mask_wdata,
    output reg [17:0] source_status,
    output reg request_line_one,
    output reg irq_pin_out,
    output reg irq_pin_oe
);
    localparam NSRC = 18;
    localparam NFLAG = 32;

    // Source indices in the raw vector
    localparam S_CLK_ERR = 0;
    localparam S_CLK_FAIL = 1;
    localparam S_BOOT = 2;
    localparam S_SIGDET = 3;
    localparam S_REF = 8;
    localparam S_LOCK = 9;

    // Flag indices in the flag vector
    localparam F_CLK_ERR = 0;
    localparam F_CLK_FAIL = 1;
    localparam F_BOOT = 2;
    localparam F_SIGDET = 3;
    localparam F_REF_LOST = 13;
    localparam F_LOCK_LOST = 14;
    localparam F_LOCK_GAINED = 15;
    localparam F_PIN = 16;

    wire [NSRC-1:0] raw_in;
    reg [NSRC-1:0] sync1_reg;
    reg [NSRC-1:0] sync2_reg;
    reg [NSRC-1:0] prev_reg;
    wire [7:0] pin_clean;
    wire [NSRC-1:0] live;
    wire [NSRC-1:0] rise;
    wire [NSRC-1:0] fall;

    reg [NFLAG-1:0] flag_reg;
    reg [NFLAG-1:0] mask_reg;
    reg [NFLAG-1:0] set_vec;
    reg [NFLAG-1:0] clr_vec;
    reg global_mask_reg;
    reg polarity_reg;
    reg drive_reg;
    reg [10:0] div_reg;
    reg slow_tick_reg;
    reg [31:0] read_word;
    wire summary;
    wire request;
    wire pin_level;
    integer k;

    // Edge or level trigger for pin sources
    function pin_trigger;
        input edge_mode;
        input edge_seen;
        input level_held;
        begin
            pin_trigger = edge_mode ? edge_seen : level_held;
        end
    endfunction

    assign raw_in = {pin_in, loop_lock_in, loop_ref_lost_in, sig_detect_in,
        boot_done_in, sysclk_fail_in, sysclk_err_in};

    // First stage feeds only the second stage
    always @(posedge clock) begin
        if (!nrst) begin
            sync1_reg <= {NSRC{1'b0}};
            sync2_reg <= {NSRC{1'b0}};
            prev_reg <= {NSRC{1'b0}};
        end else begin
            sync1_reg <= raw_in; // see [R21]
            sync2_reg <= sync1_reg;
            prev_reg <= live; // see [R21]
        end
    end

    // Slow tick for the debounce; stops with the slow clock
    always @(posedge clock) begin
        if (!nrst) begin
            div_reg <= 11'h000;
            slow_tick_reg <= 1'b0;
        end else if (!slow_clock_enable) begin
            div_reg <= 11'h000;
            slow_tick_reg <= 1'b0;
        end else if (div_reg == SLOW_DIV[10:0] - 11'h001) begin
            div_reg <= 11'h000;
            slow_tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 11'h001;
            slow_tick_reg <= 1'b0;
        end
    end

    lia_pin_debounce #(
        .WIDTH(8),
        .TICKS(DEBOUNCE_TICKS),
        .CW(4)
    ) u_debounce (
        .clock(clock),
        .nrst(nrst),
        .tick(slow_tick_reg),
        .enable(pin_debounce_en), // see [R11]
        .din(sync2_reg[NSRC-1:10]),
        .dout(pin_clean)
    );

    assign live = {pin_clean, sync2_reg[9:0]};
    assign rise = live & ~prev_reg; // see [R1]
    assign fall = ~live & prev_reg;

    // Event sources onto flags
    always @* begin
        set_vec = {NFLAG{1'b0}};
        set_vec[F_CLK_ERR] = rise[S_CLK_ERR]; // see [R2]
        set_vec[F_CLK_FAIL] = rise[S_CLK_FAIL];
        set_vec[F_BOOT] = rise[S_BOOT];
        for (k = 0; k < 5; k = k + 1) begin
            set_vec[F_SIGDET + 2*k] = rise[S_SIGDET + k]; // see [R2]
            set_vec[F_SIGDET + 2*k + 1] = fall[S_SIGDET + k];
        end
        set_vec[F_REF_LOST] = rise[S_REF];
        set_vec[F_LOCK_LOST] = fall[S_LOCK];
        set_vec[F_LOCK_GAINED] = rise[S_LOCK];
        for (k = 0; k < 8; k = k + 1) begin
            set_vec[F_PIN + 2*k] = pin_trigger(pin_rise_trigger_cfg[k],
                rise[10 + k], live[10 + k]); // see [R10]
            set_vec[F_PIN + 2*k + 1] = pin_trigger(pin_fall_trigger_cfg[k],
                fall[10 + k], ~live[10 + k]); // see [R10]
        end
    end

    // Write-one-to-clear decode
    always @* begin
        clr_vec = {NFLAG{1'b0}};
        if (reg_write) begin
            case (reg_addr)
                `LIA_OFS_CLOCK_FLAGS: begin
                    clr_vec[F_CLK_ERR] = reg_wdata[`LIA_BIT_CLK_ERR]; // see [R8]
                    clr_vec[F_CLK_FAIL] = reg_wdata[`LIA_BIT_CLK_FAIL];
                end
                `LIA_OFS_BOOT_FLAGS: begin
                    clr_vec[F_BOOT] = reg_wdata[`LIA_BIT_BOOT];
                end
                `LIA_OFS_SIGDET_FLAGS: begin
                    clr_vec[F_SIGDET+9:F_SIGDET] = reg_wdata[`LIA_BIT_SIGDET_LO+9:`LIA_BIT_SIGDET_LO];
                end
                `LIA_OFS_LOOP_FLAGS: begin
                    clr_vec[F_REF_LOST] = reg_wdata[`LIA_BIT_REF_LOST];
                    clr_vec[F_LOCK_LOST] = reg_wdata[`LIA_BIT_LOCK_LOST];
                    clr_vec[F_LOCK_GAINED] = reg_wdata[`LIA_BIT_LOCK_GAINED];
                end
                `LIA_OFS_PIN_FLAGS: begin
                    clr_vec[F_PIN+15:F_PIN] = reg_wdata[`LIA_BIT_PIN_LO+15:`LIA_BIT_PIN_LO];
                end
                default: begin
                    clr_vec = {NFLAG{1'b0}};
                end
            endcase
        end
    end

    // Flags latch regardless of mask; set beats clear
    always @(posedge clock) begin
        if (!nrst) begin
            flag_reg <= {NFLAG{1'b0}};
        end else begin
            flag_reg <= (flag_reg & ~clr_vec) | set_vec; // see [R1] see [R6] see [R8] see [R22]
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            mask_reg <= `LIA_RST_SOURCE_MASK; // see [R17]
        end else if (mask_load) begin
            mask_reg <= mask_wdata; // see [R6]
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            global_mask_reg <= `LIA_RST_GLOBAL_MASK; // see [R12]
            polarity_reg <= `LIA_RST_POLARITY; // see [R14]
            drive_reg <= `LIA_RST_DRIVE; // see [R15]
        end else if (reg_write && reg_addr == `LIA_OFS_OUT_CTRL) begin
            global_mask_reg <= reg_wdata[`LIA_BIT_GLOBAL_MASK];
            polarity_reg <= reg_wdata[`LIA_BIT_POLARITY];
            drive_reg <= reg_wdata[`LIA_BIT_DRIVE];
        end
    end

    assign summary = |(flag_reg & ~mask_reg); // see [R3] see [R7] see [R9]
    assign request = summary & ~global_mask_reg; // see [R12]
    // Polarity one means the pin sits low while asserted
    assign pin_level = polarity_reg ? ~request : request; // see [R14]

    // Register read mux
    always @* begin
        read_word = 32'h0000_0000;
        case (reg_addr)
            `LIA_OFS_OUT_CTRL: begin
                read_word[`LIA_BIT_GLOBAL_MASK] = global_mask_reg;
                read_word[`LIA_BIT_POLARITY] = polarity_reg;
                read_word[`LIA_BIT_DRIVE] = drive_reg;
            end
            `LIA_OFS_SUMMARY: begin
                read_word[`LIA_BIT_SUMMARY] = summary; // see [R13]
            end
            `LIA_OFS_CLOCK_FLAGS: begin
                read_word[`LIA_BIT_CLK_ERR] = flag_reg[F_CLK_ERR]; // see [R18]
                read_word[`LIA_BIT_CLK_FAIL] = flag_reg[F_CLK_FAIL];
            end
            `LIA_OFS_BOOT_FLAGS: begin
                read_word[`LIA_BIT_BOOT] = flag_reg[F_BOOT]; // see [R18]
            end
            `LIA_OFS_SIGDET_FLAGS: begin
                read_word[`LIA_BIT_SIGDET_LO+9:`LIA_BIT_SIGDET_LO] = flag_reg[F_SIGDET+9:F_SIGDET]; // see [R19]
            end
            `LIA_OFS_LOOP_FLAGS: begin
                read_word[`LIA_BIT_REF_LOST] = flag_reg[F_REF_LOST]; // see [R20]
                read_word[`LIA_BIT_LOCK_LOST] = flag_reg[F_LOCK_LOST];
                read_word[`LIA_BIT_LOCK_GAINED] = flag_reg[F_LOCK_GAINED];
            end
            `LIA_OFS_PIN_FLAGS: begin
                read_word[`LIA_BIT_PIN_LO+15:`LIA_BIT_PIN_LO] = flag_reg[F_PIN+15:F_PIN];
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge clock) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read) begin
                reg_rdata <= read_word; // see [R4]
            end
        end
    end

    // Outputs registered so the pin never glitches on mux settling
    always @(posedge clock) begin
        if (!nrst) begin
            source_status <= {NSRC{1'b0}};
            request_line_one <= 1'b0;
            irq_pin_out <= 1'b0;
            irq_pin_oe <= 1'b0;
        end else begin
            source_status <= live; // see [R5]
            request_line_one <= request; // see [R16]
            if (drive_reg) begin
                // Open drain only ever pulls low
                irq_pin_out <= 1'b0; // see [R15]
                irq_pin_oe <= ~pin_level;
            end else begin
                irq_pin_out <= pin_level;
                irq_pin_oe <= 1'b1;
            end
        end
    end
endmodule // lia_irq_aggregator

// ---- lia_irq_monitor.sv ----
// Port-level assertions for the latched interrupt aggregator
`timescale 1ns/10ps
`include "lia_irq_map.vh"
module lia_irq_monitor (
    input wire clock,
    input wire nrst,
    input wire [17:0] reg_addr,
    input wire reg_write,
    input wire reg_read,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire reg_rvalid,
    input wire boot_done_in,
    input wire mask_load,
    input wire [31:0] mask_wdata,
    input wire request_line_one,
    input wire irq_pin_out,
    input wire irq_pin_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    reg [2:0] ctl_reg;
    reg mall_reg;
    reg dflt_reg;
    wire ev = reg_write || mask_load;
    wire mapped = reg_addr == `LIA_OFS_OUT_CTRL || reg_addr == `LIA_OFS_SUMMARY || reg_addr == `LIA_OFS_CLOCK_FLAGS ||
        reg_addr == `LIA_OFS_BOOT_FLAGS || reg_addr == `LIA_OFS_SIGDET_FLAGS || reg_addr == `LIA_OFS_LOOP_FLAGS ||
        reg_addr == `LIA_OFS_PIN_FLAGS;
    // Shadow of {global mask, polarity, drive}; default mask state lasts until any write
    always @(posedge clock) begin
        if (!nrst) begin
            ctl_reg <= 3'h3;
            mall_reg <= 1'b0;
            dflt_reg <= 1'b1;
        end else begin
            if (reg_write && reg_addr == `LIA_OFS_OUT_CTRL) begin
                ctl_reg <= reg_wdata[11:9];
            end
            if (mask_load) begin
                mall_reg <= &mask_wdata;
            end
            if (ev) begin
                dflt_reg <= 1'b0;
            end
        end
    end
    unmapped_read_a: assert property (
        reg_read && !mapped |=> reg_rvalid && reg_rdata == 32'h0) else $error("unmapped read not zero");
    ctrl_readback_a: assert property (
        reg_read && reg_addr == `LIA_OFS_OUT_CTRL |=> reg_rdata == {20'h0, $past(ctl_reg), 9'h0})
        else $error("control readback wrong");
    global_mask_a: assert property (
        ctl_reg[2] && $past(ctl_reg[2]) |-> !request_line_one) else $error("request not globally masked");
    source_mask_a: assert property (
        mall_reg && $past(mall_reg) |-> !request_line_one) else $error("masked flags raise request");
    open_drain_a: assert property (
        $past(ctl_reg[0]) |-> !irq_pin_out && irq_pin_oe == (request_line_one == $past(ctl_reg[1])))
        else $error("open drain pin wrong");
    push_pull_a: assert property (
        !$past(ctl_reg[0]) |-> irq_pin_oe && irq_pin_out == (request_line_one ^ $past(ctl_reg[1])))
        else $error("push pull pin wrong");
    boot_request_a: assert property (
        $rose(boot_done_in) && dflt_reg |-> ##[4:5] request_line_one) else $error("boot event gave no request");
    request_hold_a: assert property (
        $fell(request_line_one) |-> $past(ev) || $past(ev, 2) || $past(ev, 3)) else $error("request dropped alone");
endmodule // lia_irq_monitor

// ---- lia_host_model.sv ----
// Host register master that polls and clears event flags
`timescale 1ns/10ps
module lia_host_model (
    input wire clock,
    output reg [17:0] reg_addr,
    output reg reg_write,
    output reg reg_read,
    output reg [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire reg_rvalid
);
    initial begin
        reg_addr = 18'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 32'h0;
    end
    // Ones clear handled flags, zeros leave the rest alone
    task wr(input [17:0] a, input [31:0] d);
        begin
            @(posedge clock);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= 1'b1;
            @(posedge clock);
            reg_write <= 1'b0;
            reg_addr <= ~a;
            reg_wdata <= ~d;
        end
    endtask
    // Polling needs no request; a missing answer reads as unknown
    task rd(input [17:0] a, output [31:0] d);
        begin
            @(posedge clock);
            reg_addr <= a;
            reg_read <= 1'b1;
            @(posedge clock);
            reg_read <= 1'b0;
            reg_addr <= ~a;
            @(posedge clock);
            d = reg_rvalid ? reg_rdata : 32'hx;
        end
    endtask
endmodule // lia_host_model

// ---- testbench.sv ----
// Self-checking bench for the latched interrupt aggregator
`timescale 1ns/10ps
`include "lia_irq_map.vh"
module testbench;
    reg clock = 1'b0, nrst = 1'b0, slow_en = 1'b0, mask_load = 1'b0;
    reg [9:0] src = 10'h0, nsrc;
    reg [7:0] pin_in = 8'h0, rise_cfg = 8'hff, fall_cfg = 8'hff, deb_en = 8'h0;
    reg [31:0] mask_wdata = 32'h0, rnd = 32'h0000_4017, got;
    reg [31:0] ef [0:3];
    wire [17:0] reg_addr, source_status;
    wire [31:0] reg_wdata, reg_rdata;
    wire reg_write, reg_read, reg_rvalid, request_line_one, irq_pin_out, irq_pin_oe;
    integer n_fail = 0, check_count = 0, i, j;
    lia_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    lia_irq_aggregator #(.SLOW_DIV(4), .DEBOUNCE_TICKS(4)) DUT (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sysclk_err_in(src[0]), .sysclk_fail_in(src[1]), .boot_done_in(src[2]), .sig_detect_in(src[7:3]),
        .loop_ref_lost_in(src[8]), .loop_lock_in(src[9]), .pin_in(pin_in), .pin_rise_trigger_cfg(rise_cfg),
        .pin_fall_trigger_cfg(fall_cfg), .pin_debounce_en(deb_en), .slow_clock_enable(slow_en), .mask_load(mask_load),
        .mask_wdata(mask_wdata), .source_status(source_status), .request_line_one(request_line_one),
        .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function [17:0] ofs(input integer k);
        ofs = k == 0 ? `LIA_OFS_CLOCK_FLAGS : k == 1 ? `LIA_OFS_BOOT_FLAGS : k == 2 ? `LIA_OFS_SIGDET_FLAGS : `LIA_OFS_LOOP_FLAGS;
    endfunction
    // Flag bits an input change o to n should set in register a
    function [31:0] edges(input [17:0] a, input [9:0] o, input [9:0] n);
        reg [9:0] r, f;
        integer k;
        begin
            r = n & ~o;
            f = o & ~n;
            edges = 32'h0;
            case (a)
                `LIA_OFS_CLOCK_FLAGS: edges = {21'h0, r[0], 1'b0, r[1], 8'h0};
                `LIA_OFS_BOOT_FLAGS: edges = {28'h0, r[2], 3'h0};
                `LIA_OFS_LOOP_FLAGS: edges = {23'h0, r[8], 6'h0, f[9], r[9]};
                default: for (k = 0; k < 5; k = k + 1) edges[16 + 2 * k +: 2] = {f[3 + k], r[3 + k]};
            endcase
        end
    endfunction
    task chk(input [31:0] e, input [31:0] g, input [8*10-1:0] nm);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                $display("mismatch %0s expected %h seen %h", nm, e, g);
                n_fail = n_fail + 1;
            end
        end
    endtask
    task rc(input [17:0] a, input [31:0] e, input [8*10-1:0] nm);
        begin
            host.rd(a, got);
            chk(e, got, nm);
        end
    endtask
    // Mask takes effect on the request pin two cycles after the load
    task ld_mask(input [31:0] m);
        begin
            mask_wdata <= m;
            mask_load <= 1'b1;
            @(posedge clock);
            mask_load <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d failures %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    initial begin
        forever #12.5 clock = ~clock;
    end
    initial begin
        #(25 * 20000);
        n_fail = n_fail + 1;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        rc(`LIA_OFS_OUT_CTRL, 32'h0000_0600, "ctrl_rst");
        chk(32'h0, {31'h0, irq_pin_oe}, "pin_idle");
        rc(18'h1_8008, 32'h0, "unmapped");
        src[0] <= 1'b1;
        repeat (8) @(posedge clock);
        chk(32'h0, {31'h0, request_line_one}, "masked");
        rc(`LIA_OFS_CLOCK_FLAGS, 32'h0000_0400, "clk_flags");
        src[2] <= 1'b1;
        repeat (8) @(posedge clock);
        chk(32'h1, {31'h0, irq_pin_oe & ~irq_pin_out}, "boot_pin");
        rc(`LIA_OFS_BOOT_FLAGS, 32'h0000_0008, "boot_flag");
        rc(`LIA_OFS_SUMMARY, 32'h0000_0001, "summary");
        host.wr(`LIA_OFS_BOOT_FLAGS, 32'h0);
        rc(`LIA_OFS_BOOT_FLAGS, 32'h0000_0008, "zero_wr");
        host.wr(`LIA_OFS_BOOT_FLAGS, 32'h0000_0008);
        repeat (3) @(posedge clock);
        chk(32'h0, {31'h0, request_line_one}, "cleared");
        ld_mask(32'h0);
        chk(32'h1, {31'h0, request_line_one}, "unmasked");
        ld_mask(32'hffff_ffff);
        chk(32'h0, {31'h0, request_line_one}, "all_mask");
        rc(`LIA_OFS_CLOCK_FLAGS, 32'h0000_0400, "mask_keep");
        rc(`LIA_OFS_SUMMARY, 32'h0, "sum_mask");
        ld_mask(32'h0);
        host.wr(`LIA_OFS_OUT_CTRL, 32'h0000_0800);
        repeat (3) @(posedge clock);
        chk(32'h0, {31'h0, request_line_one}, "gmask");
        rc(`LIA_OFS_SUMMARY, 32'h0000_0001, "sum_gmask");
        host.wr(`LIA_OFS_OUT_CTRL, 32'h0);
        repeat (3) @(posedge clock);
        chk(32'h7, {29'h0, request_line_one, irq_pin_oe, irq_pin_out}, "act_high");
        src[2] <= 1'b0;
        repeat (3) @(posedge clock);
        // Clear lands in the very cycle the new edge sets the flag
        src[2] <= 1'b1;
        @(posedge clock);
        host.wr(`LIA_OFS_BOOT_FLAGS, 32'h0000_0008);
        rc(`LIA_OFS_BOOT_FLAGS, 32'h0000_0008, "set_wins");
        ef[0] = 32'h0000_0400;
        ef[1] = 32'h0000_0008;
        ef[2] = 32'h0;
        ef[3] = 32'h0;
        for (i = 0; i < 40; i = i + 1) begin
            rnd = xs(rnd);
            nsrc = (i % 8 == 0) ? ~src : rnd[9:0];
            for (j = 0; j < 4; j = j + 1) ef[j] = ef[j] | edges(ofs(j), src, nsrc);
            src <= nsrc;
            repeat (5) @(posedge clock);
            chk({14'h0, pin_in, nsrc}, {14'h0, source_status}, "live");
            for (j = 0; j < 4; j = j + 1) rc(ofs(j), ef[j], "flags");
            chk({31'h0, |(ef[0] | ef[1] | ef[2] | ef[3])}, {31'h0, request_line_one}, "or_req");
            rnd = xs(rnd);
            for (j = 0; j < 4; j = j + 1) host.wr(ofs(j), rnd);
            for (j = 0; j < 4; j = j + 1) ef[j] = ef[j] & ~rnd;
            rc(`LIA_OFS_SUMMARY, {31'h0, |(ef[0] | ef[1] | ef[2] | ef[3])}, "sum_loop");
        end
        // Pin 2 level-high and pin 3 level-low re-set their flags every cycle
        rise_cfg <= 8'hfb;
        fall_cfg <= 8'hf7;
        deb_en <= 8'h01;
        slow_en <= 1'b1;
        pin_in <= 8'h07;
        @(posedge clock);
        pin_in[0] <= 1'b0;
        repeat (30) @(posedge clock);
        rc(`LIA_OFS_PIN_FLAGS, 32'h0094_0000, "pin_edge");
        host.wr(`LIA_OFS_PIN_FLAGS, 32'h0094_0000);
        rc(`LIA_OFS_PIN_FLAGS, 32'h0090_0000, "pin_level");
        pin_in[0] <= 1'b1;
        repeat (30) @(posedge clock);
        rc(`LIA_OFS_PIN_FLAGS, 32'h0091_0000, "debounced");
        finish_test;
    end
endmodule // testbench
bind lia_irq_aggregator lia_irq_monitor mon (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .boot_done_in(boot_done_in), .mask_load(mask_load), .mask_wdata(mask_wdata),
    .request_line_one(request_line_one), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
